// file: core/t1p_map.svh
`ifndef T1P_MAP_SVH
`define T1P_MAP_SVH

// ==========================================
// register indices, byte address = 4 * index
`define T1P_IDX_CTRL 6'h0b
`define T1P_IDX_PWMC 6'h0c
`define T1P_IDX_LATCH 6'h0d
`define T1P_IDX_STAT 6'h0e
`define T1P_IDX_MASK 6'h0f

// ==========================================
// timer_control fields
`define T1P_RUN_BIT 7
`define T1P_LOAD_BIT 6
`define T1P_SRC_HI 5
`define T1P_SRC_LO 4
`define T1P_EDGE_BIT 3
`define T1P_PS_HI 2
`define T1P_PS_LO 0

// ==========================================
// pwm_control fields
`define T1P_MODE_BIT 7
`define T1P_INIT_BIT 6
`define T1P_PIN_BIT 5
`define T1P_RATE_HI 3
`define T1P_RATE_LO 0
`define T1P_PWMC_MASK 8'hef

// ==========================================
// status and mask bits
`define T1P_ST_UFL 0
`define T1P_ST_PWM 1

// ==========================================
// reset values
`define T1P_RST_BYTE 8'h00
`define T1P_RST_EVT 2'h0

// ==========================================
// clock rates, core clock 200 MHz
`define T1P_CLK_MHZ 200
`define T1P_INSTR_MHZ 50
`define T1P_OSC_MHZ 100
`define T1P_INSTR_DIV (`T1P_CLK_MHZ / `T1P_INSTR_MHZ)
`define T1P_OSC_DIV (`T1P_CLK_MHZ / `T1P_OSC_MHZ)

`endif

// file: core/t1p_pkg.sv
package t1p_pkg;

  // ==========================================
  // counting clock source codes
  typedef enum logic [1:0] {
    SRC_EXT_PIN = 2'h0,
    SRC_INSTR = 2'h1,
    SRC_OSC = 2'h2,
    SRC_OSC_X2 = 2'h3
  } t1p_src_t;

  // ==========================================
  // state of the timer block, all but the first pin stage ext_s1
  typedef struct packed {
    logic [7:0] timer_control;
    logic [7:0] pwm_control;
    logic [7:0] timer_preset_latch;
    logic [7:0] period_timer;
    logic [6:0] presc;
    logic [7:0] div_instr;
    logic [7:0] div_osc;
    logic ext_s2;
    logic ext_s3;
    logic pwm_level;
    logic [3:0] pulse_cnt;
    logic period_start;
    logic [1:0] status;
    logic [1:0] mask;
    logic [31:0] prdata;
  } t1p_state_t;

endpackage

// file: core/t1p_timer.sv
`include "t1p_map.svh"

// Operation
// - the timer is an 8-bit down counter with a companion preset latch.
// - paired with the duty timer it forms one pwm channel, this one giving the period.
// - the timer or pwm channel runs while run_enable is 1 and stays stopped while it is 0.
// - with auto-load set a latch write also copies the value into the counter.
// - auto-load acts only at a latch write, changing the bit alone leaves the counter.
// - every underflow reloads the counter from the latch whatever auto-load says.
// - a 2-bit field picks the count clock: pin, instruction clock, oscillator, twice it.
// - with the pin as source the edge bit picks falling (1) or rising (0), else ignored.
// - a 3-bit code n divides the chosen clock by 2 to the power n.
// - mode bit 1 pairs both timers as pwm, 0 leaves them independent timers.
// - initial level 1 starts each period low going high at duty underflow, 0 the reverse.
// - the pwm output goes to port b bit 1 when pin select is 1, else to port a bit 0.
// - the pwm interrupt event fires once every rate code plus one completed pulses.
// - the latch is a read/write 8-bit register at index 0Dh.
// - bit 4 of pwm_control reads as 0.
module t1p_timer #(
  parameter int INSTR_DIV = `T1P_INSTR_DIV,
  parameter int OSC_DIV = `T1P_OSC_DIV
) (
  // clock and reset
  input wire logic CLK,
  input wire logic RST,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [31:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // external count clock pin, asynchronous
  input wire logic EXT_COUNT_CLOCK_PIN,
  // link to the duty timer
  input wire logic DUTY_TIMER_UNDERFLOW,
  output logic PERIOD_START,
  output logic PAIRED_MODE,
  // pwm pins, enables low while this block drives the pin
  output logic PORT_A_BIT0_OUT,
  output logic PORT_A_BIT0_OE_N,
  output logic PORT_B_BIT1_OUT,
  output logic PORT_B_BIT1_OE_N,
  // timer state and interrupt
  output logic [7:0] PERIOD_TIMER,
  output logic IRQ
);

  // ==========================================
  // state registers
  t1p_pkg::t1p_state_t st;
  t1p_pkg::t1p_state_t next_st;

  // first synchroniser stage, read only by ext_s2
  logic ext_s1;

  // ==========================================
  // decoded fields and bus strobes
  logic run_enable;
  logic auto_load_on_latch_write;
  t1p_pkg::t1p_src_t src_sel;
  logic ext_clock_edge_sel;
  logic [2:0] prescale_code;
  logic paired_mode_sel;
  logic initial_level_sel;
  logic output_pin_sel;
  logic [3:0] interrupt_rate_code;
  logic [5:0] idx;
  logic mapped;
  logic setup;
  logic access;
  logic wr;
  logic rd;
  logic src_tick;
  logic ext_rise;
  logic ext_fall;
  logic [6:0] presc_top;
  logic presc_pulse;
  logic step;
  logic underflow;
  logic pulse_done;
  logic instr_tick;
  logic osc_tick;
  logic [31:0] rd_word;

  // field views of the control registers
  assign run_enable = st.timer_control[`T1P_RUN_BIT];
  assign auto_load_on_latch_write = st.timer_control[`T1P_LOAD_BIT];
  assign src_sel = t1p_pkg::t1p_src_t'(st.timer_control[`T1P_SRC_HI:`T1P_SRC_LO]);
  assign ext_clock_edge_sel = st.timer_control[`T1P_EDGE_BIT];
  assign prescale_code = st.timer_control[`T1P_PS_HI:`T1P_PS_LO];
  assign paired_mode_sel = st.pwm_control[`T1P_MODE_BIT];
  assign initial_level_sel = st.pwm_control[`T1P_INIT_BIT];
  assign output_pin_sel = st.pwm_control[`T1P_PIN_BIT];
  assign interrupt_rate_code = st.pwm_control[`T1P_RATE_HI:`T1P_RATE_LO];

  // ==========================================
  // apb decode, word aligned, zero wait states
  assign idx = PADDR[7:2];
  assign mapped = (PADDR[31:8] == 24'h000000) && (PADDR[1:0] == 2'h0) &&
                  ((idx == `T1P_IDX_CTRL) || (idx == `T1P_IDX_PWMC) ||
                   (idx == `T1P_IDX_LATCH) || (idx == `T1P_IDX_STAT) ||
                   (idx == `T1P_IDX_MASK));
  assign setup = PSEL && !PENABLE;
  assign access = PSEL && PENABLE;
  assign wr = access && PWRITE && mapped;
  assign rd = access && !PWRITE && mapped;

  // handshake answers are combinational, data comes from a flop
  assign PREADY = 1'b1;
  assign PSLVERR = access && !mapped;
  assign PRDATA = st.prdata;

  // ==========================================
  // read mux, sampled in the setup cycle for the access cycle
  always_comb begin
    rd_word = 32'h00000000;
    unique case (idx)
      `T1P_IDX_CTRL: rd_word[7:0] = st.timer_control;
      `T1P_IDX_PWMC: rd_word[7:0] = st.pwm_control & `T1P_PWMC_MASK;
      `T1P_IDX_LATCH: rd_word[7:0] = st.timer_preset_latch;
      `T1P_IDX_STAT: rd_word[1:0] = st.status;
      `T1P_IDX_MASK: rd_word[1:0] = st.mask;
      default: rd_word = 32'h00000000;
    endcase
  end

  // ==========================================
  // clock source ticks, all as enables of CLK
  assign instr_tick = (st.div_instr == 8'(INSTR_DIV - 1));
  assign osc_tick = (st.div_osc == 8'(OSC_DIV - 1));

  // edge detection looks at stages two and three only
  assign ext_rise = st.ext_s2 && !st.ext_s3;
  assign ext_fall = !st.ext_s2 && st.ext_s3;

  // pick the tick, edge bit only matters for the pin
  always_comb begin
    src_tick = 1'b0;
    unique case (src_sel)
      t1p_pkg::SRC_EXT_PIN: src_tick = ext_clock_edge_sel ? ext_fall : ext_rise;
      t1p_pkg::SRC_INSTR: src_tick = instr_tick;
      t1p_pkg::SRC_OSC: src_tick = osc_tick;
      t1p_pkg::SRC_OSC_X2: src_tick = 1'b1;
    endcase
  end

  // ==========================================
  // prescaler, code n gives one pulse per 2**n ticks
  assign presc_top = 7'((8'h01 << prescale_code) - 8'h01);
  assign presc_pulse = src_tick && (st.presc >= presc_top);

  // a stopped timer takes no steps
  assign step = run_enable && presc_pulse;
  assign underflow = step && (st.period_timer == 8'h00);

  // a pwm pulse is complete when its period ends
  assign pulse_done = underflow && paired_mode_sel;

  // ==========================================
  // next state
  always_comb begin
    next_st = st;
    next_st.period_start = 1'b0;

    // free running dividers, kept running so the rates stay regular
    next_st.div_instr = instr_tick ? 8'h00 : 8'(st.div_instr + 8'h01);
    next_st.div_osc = osc_tick ? 8'h00 : 8'(st.div_osc + 8'h01);

    // second and third pin stages
    next_st.ext_s2 = ext_s1;
    next_st.ext_s3 = st.ext_s2;

    // prescaler restarts when stopped so the first period is whole
    if (!run_enable) begin
      next_st.presc = 7'h00;
    end else if (presc_pulse) begin
      next_st.presc = 7'h00;
    end else if (src_tick) begin
      next_st.presc = 7'(st.presc + 7'h01);
    end

    // down count, reload from the latch below zero
    if (underflow) begin
      next_st.period_timer = st.timer_preset_latch;
    end else if (step) begin
      next_st.period_timer = 8'(st.period_timer - 8'h01);
    end

    // pwm level: a new period starts at the inverse of the initial level
    if (underflow && paired_mode_sel) begin
      next_st.pwm_level = !initial_level_sel;
      next_st.period_start = 1'b1;
    end else if (DUTY_TIMER_UNDERFLOW && paired_mode_sel && run_enable) begin
      next_st.pwm_level = initial_level_sel;
    end

    // count completed pulses toward the interrupt rate
    if (!paired_mode_sel) begin
      next_st.pulse_cnt = 4'h0;
    end else if (pulse_done) begin
      if (st.pulse_cnt == interrupt_rate_code) begin
        next_st.pulse_cnt = 4'h0;
      end else begin
        next_st.pulse_cnt = 4'(st.pulse_cnt + 4'h1);
      end
    end

    // read data latched for the access cycle
    if (setup) begin
      next_st.prdata = rd_word;
    end

    // read of status clears it
    if (rd && (idx == `T1P_IDX_STAT)) begin
      next_st.status = `T1P_RST_EVT;
    end

    // software writes
    if (wr) begin
      unique case (idx)
        `T1P_IDX_CTRL: next_st.timer_control = PWDATA[7:0];
        `T1P_IDX_PWMC: next_st.pwm_control = PWDATA[7:0] & `T1P_PWMC_MASK;
        `T1P_IDX_LATCH: begin
          next_st.timer_preset_latch = PWDATA[7:0];
          if (auto_load_on_latch_write) begin
            next_st.period_timer = PWDATA[7:0];
          end
        end
        `T1P_IDX_MASK: next_st.mask = PWDATA[1:0];
        default: next_st.mask = st.mask;
      endcase
    end

    // events set after the clear, so a set in the clearing cycle wins
    if (underflow && !paired_mode_sel) begin
      next_st.status[`T1P_ST_UFL] = 1'b1;
    end
    if (pulse_done && (st.pulse_cnt == interrupt_rate_code)) begin
      next_st.status[`T1P_ST_PWM] = 1'b1;
    end
  end

  // ==========================================
  // registers, synchronous reset
  always_ff @(posedge CLK) begin
    if (RST) begin
      st <= '0;
      ext_s1 <= 1'b0;
    end else begin
      st <= next_st;
      ext_s1 <= EXT_COUNT_CLOCK_PIN;
    end
  end

  // ==========================================
  // outputs
  assign PERIOD_TIMER = st.period_timer;
  assign PERIOD_START = st.period_start;
  assign PAIRED_MODE = paired_mode_sel;
  assign IRQ = |(st.status & st.mask);

  // the pin not selected is released back to the port
  assign PORT_A_BIT0_OUT = st.pwm_level;
  assign PORT_B_BIT1_OUT = st.pwm_level;
  assign PORT_A_BIT0_OE_N = !(paired_mode_sel && !output_pin_sel);
  assign PORT_B_BIT1_OE_N = !(paired_mode_sel && output_pin_sel);

endmodule

// file: tb/t1p_timer_assertions.sv
// ==========================================
// port checker for the period timer
module t1p_timer_assertions (
  // clock and reset
  input wire logic CLK,
  input wire logic RST,
  // apb
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [31:0] PADDR,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  // timer and pwm
  input wire logic PERIOD_START,
  input wire logic PAIRED_MODE,
  input wire logic PORT_A_BIT0_OE_N,
  input wire logic PORT_B_BIT1_OE_N,
  input wire logic [7:0] PERIOD_TIMER,
  input wire logic IRQ
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  logic acc;
  logic mapd;
  // decode once so every bus property sees the same map
  assign acc = PSEL && PENABLE;
  assign mapd = PADDR >= 32'h2c && PADDR <= 32'h3c && PADDR[1:0] == 2'h0;
  property p_ready; PREADY; endproperty
  a_ready: assert property (p_ready) else $error("pready low");
  property p_slverr; acc |-> PSLVERR == !mapd; endproperty
  a_slverr: assert property (p_slverr) else $error("pslverr wrong");
  property p_bit4; acc && !PWRITE && PADDR == 32'h30 |-> !PRDATA[4]; endproperty
  a_bit4: assert property (p_bit4) else $error("bit4 not zero");
  property p_oe_excl; PORT_A_BIT0_OE_N || PORT_B_BIT1_OE_N; endproperty
  a_oe_excl: assert property (p_oe_excl) else $error("both pins driven");
  property p_oe_mode; !PAIRED_MODE |-> PORT_A_BIT0_OE_N && PORT_B_BIT1_OE_N; endproperty
  a_oe_mode: assert property (p_oe_mode) else $error("pin driven in timer mode");
  property p_ps_mode; PERIOD_START |-> $past(PAIRED_MODE); endproperty
  a_ps_mode: assert property (p_ps_mode) else $error("period start unpaired");
  property p_reload; PERIOD_START |-> $past(PERIOD_TIMER) == 8'h00; endproperty
  a_reload: assert property (p_reload) else $error("period start without underflow");
  // a latch write may jump the count, anything else steps by one or reloads
  property p_step;
    $changed(PERIOD_TIMER) && !$past(acc && PWRITE) |->
      PERIOD_TIMER == $past(PERIOD_TIMER) - 8'h01 || $past(PERIOD_TIMER) == 8'h00;
  endproperty
  a_step: assert property (p_step) else $error("counter jumped");
  c_ps: cover property (PERIOD_START);
  c_irq: cover property ($rose(IRQ));
  c_err: cover property (acc && PSLVERR);
endmodule

// file: tb/test_timer1_pwm_period_control.sv
`include "t1p_map.svh"

// ==========================================
// self-checking bench for the period timer
module test_timer1_pwm_period_control;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] A_CTRL = {26'h0, `T1P_IDX_CTRL, 2'h0};
  localparam logic [31:0] A_PWMC = {26'h0, `T1P_IDX_PWMC, 2'h0};
  localparam logic [31:0] A_LATCH = {26'h0, `T1P_IDX_LATCH, 2'h0};
  localparam logic [31:0] A_STAT = {26'h0, `T1P_IDX_STAT, 2'h0};
  localparam logic [31:0] A_MASK = {26'h0, `T1P_IDX_MASK, 2'h0};
  logic CLK, RST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, EXT_COUNT_CLOCK_PIN;
  logic DUTY_TIMER_UNDERFLOW, PERIOD_START, PAIRED_MODE, IRQ, serr, o;
  logic PORT_A_BIT0_OUT, PORT_A_BIT0_OE_N, PORT_B_BIT1_OUT, PORT_B_BIT1_OE_N;
  logic [31:0] PADDR, PWDATA, PRDATA, q;
  logic [7:0] PERIOD_TIMER, v;
  int err_count = 0;
  int n_checks = 0;
  int n;

  t1p_timer u_t1p_timer (.CLK, .RST, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA,
    .PREADY, .PSLVERR, .EXT_COUNT_CLOCK_PIN, .DUTY_TIMER_UNDERFLOW, .PERIOD_START,
    .PAIRED_MODE, .PORT_A_BIT0_OUT, .PORT_A_BIT0_OE_N, .PORT_B_BIT1_OUT, .PORT_B_BIT1_OE_N,
    .PERIOD_TIMER, .IRQ);

  // ==========================================
  // reporting and helpers
  task automatic stop_test;
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic tmo;
    err_count++;
    stop_test();
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge CLK);
  endtask
  // request held until pready is sampled high, data taken at that edge only
  task automatic apb(input logic wr, input logic [31:0] a, input logic [7:0] d);
    int c;
    PSEL <= 1'b1;
    PWRITE <= wr;
    PADDR <= a;
    PWDATA <= {24'h0, d};
    @(posedge CLK);
    PENABLE <= 1'b1;
    for (c = 0; c < 50; c++) begin
      @(posedge CLK);
      if (PREADY === 1'b1) break;
    end
    if (c == 50) tmo();
    q = PRDATA;
    serr = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    // one idle edge, so a following call never re-drives psel in this time step
    @(posedge CLK);
  endtask
  // wait for irq (sel 1) or a period start, counting period starts in n
  task automatic wfor(input logic sel);
    n = 0;
    for (int c = 0; c < 3000; c++) begin
      @(posedge CLK);
      if (PERIOD_START === 1'b1) n++;
      if ((sel ? IRQ : PERIOD_START) === 1'b1) return;
    end
    tmo();
  endtask
  task automatic wchg(output int c);
    v = PERIOD_TIMER;
    c = 0;
    do begin
      @(posedge CLK);
      c++;
    end while (PERIOD_TIMER === v && c < 2000);
    if (c >= 2000) tmo();
  endtask

  // ==========================================
  // scenarios
  task automatic t_regs;
    apb(1'b0, A_CTRL, 8'h00);
    chk("ctrl reset", 32'h0, q);
    apb(1'b1, A_PWMC, 8'h7f);
    apb(1'b0, A_PWMC, 8'h00);
    chk("pwmc bit4", 32'h6f, q);
    apb(1'b1, A_PWMC, 8'h00);
    apb(1'b1, A_LATCH, 8'ha5);
    apb(1'b0, A_LATCH, 8'h00);
    chk("latch", 32'ha5, q);
    apb(1'b0, 32'h40, 8'h00);
    chk("unmapped", 32'h1, 32'(serr));
    apb(1'b1, A_LATCH, 8'h12);
    tick(1);
    chk("no autoload", 32'h0, 32'(PERIOD_TIMER));
    apb(1'b1, A_CTRL, 8'h40);
    tick(1);
    chk("load bit alone", 32'h0, 32'(PERIOD_TIMER));
    apb(1'b1, A_LATCH, 8'h07);
    tick(1);
    chk("autoload", 32'h7, 32'(PERIOD_TIMER));
  endtask
  // third change is always a full step, whatever the prescaler phase
  task automatic t_rate(input logic [7:0] ctl, input int e);
    int c;
    apb(1'b1, A_CTRL, ctl);
    apb(1'b1, A_LATCH, 8'hff);
    repeat (3) wchg(c);
    chk("step period", e, c);
  endtask
  task automatic t_rates;
    for (int p = 0; p < 8; p++) t_rate(8'hf0 | p[2:0], 1 << p);
    t_rate(8'hd1, 8);
    t_rate(8'he1, 4);
    apb(1'b1, A_CTRL, 8'h70);
    tick(1);
    v = PERIOD_TIMER;
    tick(20);
    chk("stopped", 32'(v), 32'(PERIOD_TIMER));
  endtask
  // pin pulses long enough to cross the synchroniser
  task automatic pulses(input int k);
    repeat (k) begin
      EXT_COUNT_CLOCK_PIN <= 1'b1;
      tick(6);
      EXT_COUNT_CLOCK_PIN <= 1'b0;
      tick(6);
    end
  endtask
  task automatic t_pin;
    apb(1'b1, A_CTRL, 8'hc0);
    apb(1'b1, A_LATCH, 8'h40);
    pulses(3);
    chk("rising edges", 32'h3d, 32'(PERIOD_TIMER));
    apb(1'b1, A_CTRL, 8'h88);
    pulses(2);
    chk("falling edges", 32'h3b, 32'(PERIOD_TIMER));
  endtask
  task automatic t_irq;
    apb(1'b1, A_MASK, 8'h01);
    apb(1'b0, A_STAT, 8'h00);
    apb(1'b1, A_CTRL, 8'hf0);
    apb(1'b1, A_LATCH, 8'h02);
    wfor(1'b1);
    chk("reload", 32'h2, 32'(PERIOD_TIMER));
    apb(1'b1, A_CTRL, 8'h30);
    apb(1'b0, A_STAT, 8'h00);
    chk("status", 32'h1, q);
    tick(1);
    chk("irq cleared", 32'h0, 32'(IRQ));
    apb(1'b1, A_MASK, 8'h00);
    apb(1'b1, A_CTRL, 8'hf0);
    tick(10);
    chk("irq masked", 32'h0, 32'(IRQ));
    apb(1'b1, A_CTRL, 8'h30);
  endtask
  task automatic t_pwm(input logic i);
    apb(1'b1, A_PWMC, {1'b1, i, i, 5'h02});
    apb(1'b1, A_MASK, 8'h02);
    chk("paired", 32'h1, 32'(PAIRED_MODE));
    chk("pins", {30'h0, i, !i}, {30'h0, PORT_A_BIT0_OE_N, PORT_B_BIT1_OE_N});
    apb(1'b1, A_CTRL, 8'hf3);
    apb(1'b1, A_LATCH, 8'h03);
    wfor(1'b0);
    tick(1);
    o = i ? PORT_B_BIT1_OUT : PORT_A_BIT0_OUT;
    chk("period level", 32'(!i), 32'(o));
    DUTY_TIMER_UNDERFLOW <= 1'b1;
    tick(1);
    DUTY_TIMER_UNDERFLOW <= 1'b0;
    tick(1);
    o = i ? PORT_B_BIT1_OUT : PORT_A_BIT0_OUT;
    chk("duty level", 32'(i), 32'(o));
    wfor(1'b1);
    apb(1'b0, A_STAT, 8'h00);
    wfor(1'b1);
    chk("pulses per event", 32'h3, n);
    apb(1'b0, A_STAT, 8'h00);
    chk("status pwm", 32'h2, q);
    apb(1'b1, A_CTRL, 8'h00);
    apb(1'b1, A_PWMC, 8'h00);
  endtask

  // ==========================================
  // clock and main sequence
  initial begin
    CLK = 1'b0;
    forever #2.5 CLK = ~CLK;
  end
  initial begin
    RST = 1'b1;
    PSEL = 1'b0;
    PENABLE = 1'b0;
    PWRITE = 1'b0;
    PADDR = 32'h0;
    PWDATA = 32'h0;
    EXT_COUNT_CLOCK_PIN = 1'b0;
    DUTY_TIMER_UNDERFLOW = 1'b0;
    repeat (8) @(posedge CLK);
    RST <= 1'b0;
    @(posedge CLK);
    t_regs();
    t_rates();
    t_pin();
    t_irq();
    t_pwm(1'b0);
    t_pwm(1'b1);
    stop_test();
  end
endmodule

bind t1p_timer t1p_timer_assertions u_t1p_timer_assertions (.CLK, .RST, .PSEL, .PENABLE,
  .PWRITE, .PADDR, .PRDATA, .PREADY, .PSLVERR, .PERIOD_START, .PAIRED_MODE,
  .PORT_A_BIT0_OE_N, .PORT_B_BIT1_OE_N, .PERIOD_TIMER, .IRQ);
